// [tirv_chan_model.sv]
// channel current source standing in for the three upstream sensors
`timescale 1ns/1ps
module tirv_chan_model
  import tirv_pkg::*;
(
  input wire logic aclk,
  input wire tirv_regions_t want,
  output logic [15:0] ch0_current,
  output logic [15:0] ch1_current,
  output logic [15:0] ch2_current
);
  integer seed = 61;

  // noisy current inside the wanted region, default thresholds
  function automatic logic [15:0] pick(input tirv_region_t r, input logic [15:0] n);
    case (r)
      TIRV_LOWER_TRIP: pick = n % 16'h0400;
      TIRV_LOW: pick = 16'h0400 + n % 16'h0C00;
      TIRV_NORMAL: pick = 16'h1000 + n % 16'hB001;
      TIRV_HIGH: pick = 16'hC001 + n % 16'h3000;
      default: pick = 16'hF001 + n % 16'h0FFF;
    endcase
  endfunction

  // idle currents at time zero
  initial begin
    ch0_current = 16'h0000;
    ch1_current = 16'h0000;
    ch2_current = 16'h0000;
  end

  // fresh sample every cycle so the region logic sees changing codes
  always @(posedge aclk) begin
    ch0_current <= pick(want.ch0, 16'($random(seed)));
    ch1_current <= pick(want.ch1, 16'($random(seed)));
    ch2_current <= pick(want.ch2, 16'($random(seed)));
  end
endmodule

// [tirv_top.sv]
// triple input region voter with fault latch timers and register slave
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module tirv_top
  import tirv_pkg::*;
#(
  parameter int TICK_CYCLES = TIRV_TICK_CYCLES,
  parameter bit DUAL_TIMER = 1'b1
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] ch0_current,
  input wire logic [15:0] ch1_current,
  input wire logic [15:0] ch2_current,
  input wire logic run_mode,
  input wire logic [3:0] dig_fault_evt,
  input wire logic [3:0] ana_fault_evt,
  output tirv_region_t voted_region,
  output logic [3:0] dig_fault_latched,
  output logic [3:0] ana_fault_latched,
  output logic failsafe_req,
  output logic irq
);
  // byte lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
      input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  // bus channel state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;

  // software registers
  logic [15:0] latch_time_q, th_lt_q, th_lo_q, th_hi_q, th_ut_q;
  logic [3:0] istat_q, istat_d, imask_q;
  logic [7:0] fsen_q;

  // datapath state
  tirv_regions_t regions_q;
  tirv_regions_t regions_d;
  tirv_region_t voted_q, vote_w;
  logic [3:0] dlat_q, dlat_d, alat_q, alat_d;
  logic run_mode_q;
  logic failsafe_q, irq_q;
  logic [15:0] cnt_q [2];
  logic [15:0] pre_q [2];
  logic [1:0] load, tick, expire, idle;

  // channel handshakes and write decode
  wire aw_fire = s_axi_awvalid & awready_q;
  wire w_fire = s_axi_wvalid & wready_q;
  wire ar_fire = s_axi_arvalid & arready_q;
  wire wr_en = aw_have_q & w_have_q;
  wire wr_latch = wr_en && aw_addr_q == TIRV_OFS_LATCH;
  wire wr_lt = wr_en && aw_addr_q == TIRV_OFS_TH_LT;
  wire wr_lo = wr_en && aw_addr_q == TIRV_OFS_TH_LO;
  wire wr_hi = wr_en && aw_addr_q == TIRV_OFS_TH_HI;
  wire wr_ut = wr_en && aw_addr_q == TIRV_OFS_TH_UT;
  wire wr_istat = wr_en && aw_addr_q == TIRV_OFS_ISTAT && w_strb_q[0];
  wire wr_imask = wr_en && aw_addr_q == TIRV_OFS_IMASK && w_strb_q[0];
  wire wr_fsen = wr_en && aw_addr_q == TIRV_OFS_FSEN && w_strb_q[0];
  wire wr_mapped = wr_latch | wr_lt | wr_lo | wr_hi | wr_ut
    | (wr_en && (aw_addr_q == TIRV_OFS_REGION || aw_addr_q == TIRV_OFS_FAULT
    || aw_addr_q == TIRV_OFS_ISTAT || aw_addr_q == TIRV_OFS_IMASK
    || aw_addr_q == TIRV_OFS_FSEN));

  // next state of the five channels, one write and one read at a time
  assign aw_have_d = (aw_have_q | aw_fire) & ~wr_en;
  assign w_have_d = (w_have_q | w_fire) & ~wr_en;
  assign bvalid_d = wr_en | (bvalid_q & ~s_axi_bready);
  assign awready_d = ~aw_have_d & ~bvalid_d;
  assign wready_d = ~w_have_d & ~bvalid_d;
  assign rvalid_d = ar_fire | (rvalid_q & ~s_axi_rready);
  assign arready_d = ~rvalid_d;

  // read selection, unmapped reads zero with an error answer
  wire [31:0] rd_region = {17'h0000, voted_q, 1'b0, regions_q.ch2, 1'b0, regions_q.ch1,
    1'b0, regions_q.ch0};
  wire [31:0] rd_fault = {22'h00000, |cnt_q[1], |cnt_q[0], alat_q, dlat_q};
  wire rd_hit_latch = s_axi_araddr == TIRV_OFS_LATCH;
  wire rd_hit_lt = s_axi_araddr == TIRV_OFS_TH_LT;
  wire rd_hit_lo = s_axi_araddr == TIRV_OFS_TH_LO;
  wire rd_hit_hi = s_axi_araddr == TIRV_OFS_TH_HI;
  wire rd_hit_ut = s_axi_araddr == TIRV_OFS_TH_UT;
  wire rd_hit_reg = s_axi_araddr == TIRV_OFS_REGION;
  wire rd_hit_flt = s_axi_araddr == TIRV_OFS_FAULT;
  wire rd_hit_ist = s_axi_araddr == TIRV_OFS_ISTAT;
  wire rd_hit_imk = s_axi_araddr == TIRV_OFS_IMASK;
  wire rd_hit_fse = s_axi_araddr == TIRV_OFS_FSEN;
  wire rd_hit = rd_hit_latch | rd_hit_lt | rd_hit_lo | rd_hit_hi | rd_hit_ut | rd_hit_reg
    | rd_hit_flt | rd_hit_ist | rd_hit_imk | rd_hit_fse;
  wire [31:0] rd_mux = rd_hit_latch ? {16'h0000, latch_time_q}
    : rd_hit_lt ? {16'h0000, th_lt_q}
    : rd_hit_lo ? {16'h0000, th_lo_q}
    : rd_hit_hi ? {16'h0000, th_hi_q}
    : rd_hit_ut ? {16'h0000, th_ut_q}
    : rd_hit_reg ? rd_region
    : rd_hit_flt ? rd_fault
    : rd_hit_ist ? {28'h0000000, istat_q}
    : rd_hit_imk ? {28'h0000000, imask_q}
    : rd_hit_fse ? {24'h000000, fsen_q}
    : 32'h00000000;

  // bus channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
    end
  end

  // captured payloads and answers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bresp_q <= TIRV_RESP_OKAY;
      rdata_q <= 32'h00000000;
      rresp_q <= TIRV_RESP_OKAY;
    end else begin
      if (aw_fire) aw_addr_q <= s_axi_awaddr;
      if (w_fire) w_data_q <= s_axi_wdata;
      if (w_fire) w_strb_q <= s_axi_wstrb;
      if (wr_en) bresp_q <= wr_mapped ? TIRV_RESP_OKAY : TIRV_RESP_SLVERR;
      if (ar_fire) rdata_q <= rd_mux;
      if (ar_fire) rresp_q <= rd_hit ? TIRV_RESP_OKAY : TIRV_RESP_SLVERR;
    end
  end

  // latch time and thresholds
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_time_q <= TIRV_RST_LATCH;
      th_lt_q <= TIRV_RST_TH_LT;
      th_lo_q <= TIRV_RST_TH_LO;
      th_hi_q <= TIRV_RST_TH_HI;
      th_ut_q <= TIRV_RST_TH_UT;
    end else begin
      if (wr_latch) latch_time_q <= merge16(latch_time_q, w_data_q, w_strb_q);
      if (wr_lt) th_lt_q <= merge16(th_lt_q, w_data_q, w_strb_q);
      if (wr_lo) th_lo_q <= merge16(th_lo_q, w_data_q, w_strb_q);
      if (wr_hi) th_hi_q <= merge16(th_hi_q, w_data_q, w_strb_q);
      if (wr_ut) th_ut_q <= merge16(th_ut_q, w_data_q, w_strb_q);
    end
  end

  // per-channel classification
  assign regions_d.ch0 = tirv_classify(ch0_current, th_lt_q, th_lo_q, th_hi_q, th_ut_q);
  assign regions_d.ch1 = tirv_classify(ch1_current, th_lt_q, th_lo_q, th_hi_q, th_ut_q);
  assign regions_d.ch2 = tirv_classify(ch2_current, th_lt_q, th_lo_q, th_hi_q, th_ut_q);

  tirv_voter u_voter (
    .regions(regions_q),
    .voted(vote_w)
  );

  // fault timers, index 0 digital and 1 analog
  assign load[0] = DUAL_TIMER ? |dig_fault_evt : |{dig_fault_evt, ana_fault_evt};
  assign load[1] = DUAL_TIMER ? |ana_fault_evt : |{dig_fault_evt, ana_fault_evt};
  assign tick[0] = pre_q[0] == 16'(TICK_CYCLES - 1);
  assign tick[1] = pre_q[1] == 16'(TICK_CYCLES - 1);
  assign idle[0] = cnt_q[0] == 16'h0000 && !load[0];
  assign idle[1] = cnt_q[1] == 16'h0000 && !load[1];
  assign expire[0] = cnt_q[0] == 16'h0001 && tick[0] && !load[0];
  assign expire[1] = cnt_q[1] == 16'h0001 && tick[1] && !load[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2; i++) begin
        cnt_q[i] <= 16'h0000;
        pre_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (load[i]) begin
          cnt_q[i] <= latch_time_q;
          pre_q[i] <= 16'h0000;
        end else if (cnt_q[i] != 16'h0000) begin
          cnt_q[i] <= tick[i] ? cnt_q[i] - 16'h0001 : cnt_q[i];
          pre_q[i] <= tick[i] ? 16'h0000 : pre_q[i] + 16'h0001;
        end
      end
    end
  end

  // latched faults: new events win, cleared only by an idle timer, mode ignored
  assign dlat_d = (idle[0] ? 4'h0 : dlat_q) | dig_fault_evt;
  assign alat_d = (idle[1] ? 4'h0 : alat_q) | ana_fault_evt;

  // interrupt status, set beats write-one-to-clear
  wire [3:0] istat_set = {|expire, voted_q != vote_w, |ana_fault_evt, |dig_fault_evt};
  assign istat_d = (istat_q & ~(wr_istat ? w_data_q[3:0] : 4'h0)) | istat_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regions_q <= '{TIRV_LOWER_TRIP, TIRV_LOWER_TRIP, TIRV_LOWER_TRIP};
      voted_q <= TIRV_LOWER_TRIP;
      dlat_q <= 4'h0;
      alat_q <= 4'h0;
      run_mode_q <= 1'b0;
    end else begin
      regions_q <= regions_d;
      voted_q <= vote_w;
      dlat_q <= dlat_d;
      alat_q <= alat_d;
      run_mode_q <= run_mode;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_q <= 4'h0;
      imask_q <= TIRV_RST_IMASK;
      fsen_q <= TIRV_RST_FSEN;
      failsafe_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      istat_q <= istat_d;
      if (wr_imask) imask_q <= w_data_q[3:0];
      if (wr_fsen) fsen_q <= w_data_q[7:0];
      failsafe_q <= |({alat_q, dlat_q} & fsen_q);
      irq_q <= |(istat_q & imask_q);
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign voted_region = voted_q;
  assign dig_fault_latched = dlat_q;
  assign ana_fault_latched = alat_q;
  assign failsafe_req = failsafe_q;
  assign irq = irq_q;

  // checks on the classifier, voter, timers, latches and fail-safe
  property p_lt_class;
    @(posedge aclk) disable iff (!aresetn)
    ch0_current < th_lt_q && !wr_en |=> regions_q.ch0 == TIRV_LOWER_TRIP;
  endproperty
  a_lt_class: assert property (p_lt_class) else $error("low current not lower trip");

  property p_two_lt;
    @(posedge aclk) disable iff (!aresetn)
    regions_q.ch0 == TIRV_LOWER_TRIP && regions_q.ch2 == TIRV_LOWER_TRIP
      |=> voted_q == TIRV_LOWER_TRIP;
  endproperty
  a_two_lt: assert property (p_two_lt) else $error("two lower trips not voted");

  property p_ut_over_low;
    @(posedge aclk) disable iff (!aresetn)
    regions_q == tirv_regions_t'{TIRV_LOW, TIRV_UPPER_TRIP, TIRV_UPPER_TRIP}
      |=> voted_q == TIRV_UPPER_TRIP;
  endproperty
  a_ut_over_low: assert property (p_ut_over_low) else $error("upper trip rank wrong");

  property p_high_low;
    @(posedge aclk) disable iff (!aresetn)
    regions_q == tirv_regions_t'{TIRV_LOW, TIRV_HIGH, TIRV_HIGH} |=> voted_q == TIRV_HIGH;
  endproperty
  a_high_low: assert property (p_high_low) else $error("high low rank wrong");

  property p_table_ex;
    @(posedge aclk) disable iff (!aresetn)
    regions_q == tirv_regions_t'{TIRV_LOWER_TRIP, TIRV_HIGH, TIRV_UPPER_TRIP}
      |=> voted_q == TIRV_UPPER_TRIP;
  endproperty
  a_table_ex: assert property (p_table_ex) else $error("voting example wrong");

  property p_same;
    @(posedge aclk) disable iff (!aresetn)
    regions_q.ch0 == regions_q.ch1 && regions_q.ch1 == regions_q.ch2
      |=> voted_q == $past(regions_q.ch0);
  endproperty
  a_same: assert property (p_same) else $error("unanimous vote changed");

  property p_fault_set;
    @(posedge aclk) disable iff (!aresetn)
    dig_fault_evt[0] |=> dlat_q[0] ##0 cnt_q[0] == $past(latch_time_q);
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");

  property p_no_cross;
    @(posedge aclk) disable iff (!aresetn)
    DUAL_TIMER && |ana_fault_evt && !(|dig_fault_evt)
      |=> cnt_q[0] <= $past(cnt_q[0]);
  endproperty
  a_no_cross: assert property (p_no_cross) else $error("analog fault hit digital timer");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
    alat_q[0] && cnt_q[1] > 16'h0001 |=> alat_q[0] [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("fault dropped early");

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    idle[0] && !(|dig_fault_evt) |=> dlat_q == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("expired fault not cleared");

  property p_mode;
    @(posedge aclk) disable iff (!aresetn)
    run_mode != run_mode_q && !idle[0] |=> dlat_q == ($past(dlat_q) | $past(dig_fault_evt));
  endproperty
  a_mode: assert property (p_mode) else $error("mode change touched faults");

  property p_failsafe;
    @(posedge aclk) disable iff (!aresetn)
    |({alat_q, dlat_q} & fsen_q) |=> failsafe_req;
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("held fault did not force fail-safe");
endmodule

// [tirv_top_tb.sv]
// self-checking bench for the triple input region voter
`timescale 1ns/1ps
module tirv_top_tb
  import tirv_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, failsafe_req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] c0, c1, c2;
  logic run_mode = 1'b0;
  logic [3:0] dig_evt = 4'h0, ana_evt = 4'h0, dig_lat, ana_lat;
  tirv_region_t voted;
  tirv_regions_t want = '0;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int err_total = 0, tests_run = 0;

  // clock and reset
  initial begin
    forever #20 aclk = ~aclk;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  end

  tirv_chan_model model (.aclk(aclk), .want(want), .ch0_current(c0), .ch1_current(c1),
    .ch2_current(c2));

  tirv_top #(.TICK_CYCLES(4), .DUAL_TIMER(1'b1)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ch0_current(c0), .ch1_current(c1), .ch2_current(c2), .run_mode(run_mode),
    .dig_fault_evt(dig_evt), .ana_fault_evt(ana_evt), .voted_region(voted),
    .dig_fault_latched(dig_lat), .ana_fault_latched(ana_lat), .failsafe_req(failsafe_req),
    .irq(irq));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // bus write, expected response queued for the monitor
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // bus read, expected data and response queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({d, r});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // monitor takes the oldest note whenever an answer is handed over
  always @(posedge aclk) begin
    logic [33:0] e;
    if (bvalid && bready) chk("bresp", 32'(bq.pop_front()), 32'(bresp));
    if (rvalid && rready) begin
      e = rq.pop_front();
      chk("rdata", e[33:2], rdata);
      chk("rresp", 32'(e[1:0]), 32'(rresp));
    end
  end

  // safety rank, zero safest
  function automatic int rk(input int r);
    case (r)
      0: rk = 0;
      4: rk = 1;
      1: rk = 2;
      3: rk = 3;
      default: rk = 4;
    endcase
  endfunction
  function automatic int sf(input int a, input int b);
    sf = (rk(a) <= rk(b)) ? a : b;
  endfunction
  function automatic int ls(input int a, input int b);
    ls = (rk(a) >= rk(b)) ? a : b;
  endfunction

  task automatic pulse(input logic [3:0] d, input logic [3:0] a);
    @(posedge aclk);
    dig_evt <= d;
    ana_evt <= a;
    @(posedge aclk);
    dig_evt <= 4'h0;
    ana_evt <= 4'h0;
  endtask

  task automatic see(input string n, input logic [31:0] e, input logic [31:0] s);
    chk(n, e, s);
  endtask

  initial begin
    #400000;
    err_total++;
    finish_test();
  end

  // main sequence
  initial begin
    int v;
    @(posedge aclk iff aresetn);
    rd(TIRV_OFS_LATCH, 32'h64, TIRV_RESP_OKAY);
    rd(TIRV_OFS_TH_LT, 32'h400, TIRV_RESP_OKAY);
    rd(TIRV_OFS_TH_UT, 32'hF000, TIRV_RESP_OKAY);
    rd(TIRV_OFS_IMASK, 32'h0, TIRV_RESP_OKAY);
    rd(TIRV_OFS_FSEN, 32'hFF, TIRV_RESP_OKAY);
    rd(8'h40, 32'h0, TIRV_RESP_SLVERR);
    wr(8'h40, 32'h1, TIRV_RESP_SLVERR);
    wr(TIRV_OFS_REGION, 32'hFFFF, TIRV_RESP_OKAY);
    // every ordered combination of three channel regions
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 5; j++) begin
        for (int k = 0; k < 5; k++) begin
          v = ls(ls(sf(i, j), sf(j, k)), sf(i, k));
          @(posedge aclk);
          want <= {tirv_region_t'(3'(k)), tirv_region_t'(3'(j)), tirv_region_t'(3'(i))};
          repeat (3) @(posedge aclk);
          @(negedge aclk);
          see("voted", 32'(v), 32'(voted));
          rd(TIRV_OFS_REGION, {17'h0, 3'(v), 1'b0, 3'(k), 1'b0, 3'(j), 1'b0, 3'(i)},
            TIRV_RESP_OKAY);
        end
      end
    end
    // latch timers, four ticks of four cycles
    wr(TIRV_OFS_LATCH, 32'h4, TIRV_RESP_OKAY);
    pulse(4'h1, 4'h0);
    repeat (2) @(negedge aclk);
    see("dig_lat", 32'h1, 32'(dig_lat));
    see("failsafe", 32'h1, 32'(failsafe_req));
    repeat (8) @(posedge aclk);
    ana_evt <= 4'h3;
    @(posedge aclk);
    ana_evt <= 4'h0;
    run_mode <= 1'b1;
    repeat (2) @(negedge aclk);
    see("dig_lat", 32'h1, 32'(dig_lat));
    see("ana_lat", 32'h3, 32'(ana_lat));
    repeat (6) @(posedge aclk);
    run_mode <= 1'b0;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    see("dig_lat", 32'h0, 32'(dig_lat));
    see("ana_lat", 32'h3, 32'(ana_lat));
    repeat (20) @(posedge aclk);
    rd(TIRV_OFS_FAULT, 32'h0, TIRV_RESP_OKAY);
    rd(TIRV_OFS_ISTAT, 32'hF, TIRV_RESP_OKAY);
    wr(TIRV_OFS_ISTAT, 32'hF, TIRV_RESP_OKAY);
    rd(TIRV_OFS_ISTAT, 32'h0, TIRV_RESP_OKAY);
    // interrupt raised, masked and cleared
    wr(TIRV_OFS_IMASK, 32'h1, TIRV_RESP_OKAY);
    pulse(4'h8, 4'h0);
    repeat (3) @(negedge aclk);
    see("irq", 32'h1, 32'(irq));
    rd(TIRV_OFS_ISTAT, 32'h1, TIRV_RESP_OKAY);
    wr(TIRV_OFS_IMASK, 32'h0, TIRV_RESP_OKAY);
    repeat (2) @(negedge aclk);
    see("irq", 32'h0, 32'(irq));
    wr(TIRV_OFS_IMASK, 32'h1, TIRV_RESP_OKAY);
    repeat (2) @(negedge aclk);
    see("irq", 32'h1, 32'(irq));
    wr(TIRV_OFS_ISTAT, 32'h1, TIRV_RESP_OKAY);
    repeat (2) @(negedge aclk);
    see("irq", 32'h0, 32'(irq));
    // fail-safe enable limited to the analog half
    wr(TIRV_OFS_FSEN, 32'hF0, TIRV_RESP_OKAY);
    rd(TIRV_OFS_FSEN, 32'hF0, TIRV_RESP_OKAY);
    pulse(4'h1, 4'h0);
    repeat (2) @(negedge aclk);
    see("dig_lat", 32'h1, 32'(dig_lat));
    see("failsafe", 32'h0, 32'(failsafe_req));
    repeat (4) @(posedge aclk);
    finish_test();
  end
endmodule

// [tirv_voter.sv]
// constants, types, helper functions and the two-stage region voter
`timescale 1ns/1ps
package tirv_pkg;
  typedef enum logic [2:0] {
    TIRV_LOWER_TRIP = 3'h0,
    TIRV_LOW = 3'h1,
    TIRV_NORMAL = 3'h2,
    TIRV_HIGH = 3'h3,
    TIRV_UPPER_TRIP = 3'h4
  } tirv_region_t;

  // three channel codes moving together into the voter
  typedef struct packed {
    tirv_region_t ch2;
    tirv_region_t ch1;
    tirv_region_t ch0;
  } tirv_regions_t;

  // register byte offsets
  localparam logic [7:0] TIRV_OFS_LATCH = 8'h00;
  localparam logic [7:0] TIRV_OFS_TH_LT = 8'h04;
  localparam logic [7:0] TIRV_OFS_TH_LO = 8'h08;
  localparam logic [7:0] TIRV_OFS_TH_HI = 8'h0C;
  localparam logic [7:0] TIRV_OFS_TH_UT = 8'h10;
  localparam logic [7:0] TIRV_OFS_REGION = 8'h14;
  localparam logic [7:0] TIRV_OFS_FAULT = 8'h18;
  localparam logic [7:0] TIRV_OFS_ISTAT = 8'h1C;
  localparam logic [7:0] TIRV_OFS_IMASK = 8'h20;
  localparam logic [7:0] TIRV_OFS_FSEN = 8'h24;

  // reset values
  localparam logic [15:0] TIRV_RST_LATCH = 16'h0064;
  localparam logic [15:0] TIRV_RST_TH_LT = 16'h0400;
  localparam logic [15:0] TIRV_RST_TH_LO = 16'h1000;
  localparam logic [15:0] TIRV_RST_TH_HI = 16'hC000;
  localparam logic [15:0] TIRV_RST_TH_UT = 16'hF000;
  localparam logic [7:0] TIRV_RST_FSEN = 8'hFF;
  localparam logic [3:0] TIRV_RST_IMASK = 4'h0;

  // interrupt status bit positions
  localparam int TIRV_IRQ_DIG = 0;
  localparam int TIRV_IRQ_ANA = 1;
  localparam int TIRV_IRQ_VOTE = 2;
  localparam int TIRV_IRQ_EXP = 3;

  // fault register field positions
  localparam int TIRV_FLT_ANA_LSB = 4;
  localparam int TIRV_FLT_DRUN = 8;
  localparam int TIRV_FLT_ARUN = 9;

  // bus responses
  localparam logic [1:0] TIRV_RESP_OKAY = 2'h0;
  localparam logic [1:0] TIRV_RESP_SLVERR = 2'h2;

  // latch time unit is one millisecond
  localparam int TIRV_CLK_PERIOD_NS = 40;
  localparam int TIRV_LATCH_UNIT_NS = 1000000;
  localparam int TIRV_TICK_CYCLES = TIRV_LATCH_UNIT_NS / TIRV_CLK_PERIOD_NS;

  // safety rank, zero is safest
  function automatic logic [2:0] tirv_rank(input tirv_region_t r);
    unique case (r)
      TIRV_LOWER_TRIP: tirv_rank = 3'h0;
      TIRV_UPPER_TRIP: tirv_rank = 3'h1;
      TIRV_LOW: tirv_rank = 3'h2;
      TIRV_HIGH: tirv_rank = 3'h3;
      TIRV_NORMAL: tirv_rank = 3'h4;
      default: tirv_rank = 3'h4;
    endcase
  endfunction

  function automatic tirv_region_t tirv_safer(input tirv_region_t a, input tirv_region_t b);
    tirv_safer = (tirv_rank(a) <= tirv_rank(b)) ? a : b;
  endfunction

  function automatic tirv_region_t tirv_less_safe(input tirv_region_t a, input tirv_region_t b);
    tirv_less_safe = (tirv_rank(a) >= tirv_rank(b)) ? a : b;
  endfunction

  // current to region against ascending thresholds
  function automatic tirv_region_t tirv_classify(input logic [15:0] cur, input logic [15:0] lt,
      input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] ut);
    if (cur < lt) begin
      tirv_classify = TIRV_LOWER_TRIP;
    end else if (cur < lo) begin
      tirv_classify = TIRV_LOW;
    end else if (cur <= hi) begin
      tirv_classify = TIRV_NORMAL;
    end else if (cur <= ut) begin
      tirv_classify = TIRV_HIGH;
    end else begin
      tirv_classify = TIRV_UPPER_TRIP;
    end
  endfunction
endpackage

module tirv_voter
  import tirv_pkg::*;
(
  input wire tirv_regions_t regions,
  output tirv_region_t voted
);
  tirv_region_t ref01;
  tirv_region_t ref12;
  tirv_region_t ref02;

  // pessimistic pairwise stage
  assign ref01 = tirv_safer(regions.ch0, regions.ch1);
  assign ref12 = tirv_safer(regions.ch1, regions.ch2);
  assign ref02 = tirv_safer(regions.ch0, regions.ch2);

  // optimistic stage over the pair results
  assign voted = tirv_less_safe(tirv_less_safe(ref01, ref12), ref02);
endmodule
